/* File: hdl/spfs_pkg.sv */
package spfs_pkg;

    // ***************************************
    // Pin counts and layout
    // ***************************************
    localparam int PIN_COUNT = 21;
    localparam int AN_COUNT  = 12;
    // Pin index of the first converter analog input
    localparam int AN_BASE   = 6;

    // ***************************************
    // Pin indices of shared resources
    // ***************************************
    localparam int IDX_PULSE_GEN0    = 0;
    localparam int IDX_PULSE_GEN1    = 1;
    localparam int IDX_UART0_RX      = 2;
    localparam int IDX_UART0_CLOCK   = 3;
    localparam int IDX_UART0_TX      = 4;
    localparam int IDX_UART1_RX      = 5;
    localparam int IDX_UART1_CLOCK   = 15;
    localparam int IDX_SIO1_OUT      = 16;
    localparam int IDX_SIO2_IN       = 17;
    localparam int IDX_SDA           = 18;
    localparam int IDX_SCL           = 19;

    // ***************************************
    // Reset values
    // ***************************************
    localparam logic [AN_COUNT-1:0]  AIN_RESET   = 12'hFFF;
    localparam logic [PIN_COUNT-1:0] PIN_ZERO    = 21'h00_0000;
    localparam logic [PIN_COUNT-1:0] PIN_ONES    = 21'h1F_FFFF;
    localparam logic [AN_COUNT-1:0]  AIN_ZERO    = 12'h000;

endpackage : spfs_pkg

/* File: hdl/spfs_pin_mux.sv */
`timescale 1ns/1ps
`default_nettype none

// Function
// - A pin reaches the converter only while its analog enable bit is 1.
// - Standby blocks every hysteresis input path from internal logic.
// - A uart clock pin is driven by its uart only when clock out is on.
// - A serial input pin in receive mode is dedicated to its channel.
// - Port and resources share one output and one input path per pin.
// - The two-wire bus pins only pull low, never drive high.
// - A serial data out pin carries the channel only when output is on.
// - After reset every analog enable bit reads 1.
module spfs_pin_mux
    import spfs_pkg::*;
(
    input  wire logic                 SYS_CLK,
    input  wire logic                 RST_B,
    input  wire logic [PIN_COUNT-1:0] PIN_IN,
    output var  logic [PIN_COUNT-1:0] PIN_OUT,
    output var  logic [PIN_COUNT-1:0] PIN_OE_B,
    input  wire logic [PIN_COUNT-1:0] PORT_DATA,
    input  wire logic [PIN_COUNT-1:0] PORT_DIR,
    input  wire logic [PIN_COUNT-1:0] RES_OUT,
    input  wire logic [PIN_COUNT-1:0] RES_OE,
    input  wire logic                 RX_ACTIVE_UART0,
    input  wire logic                 RX_ACTIVE_UART1,
    input  wire logic                 RX_ACTIVE_SIO2,
    input  wire logic                 BUS_ACTIVE,
    input  wire logic                 BUS_SDA_LOW,
    input  wire logic                 BUS_SCL_LOW,
    input  wire logic                 STANDBY,
    input  wire logic                 AIN_WR,
    input  wire logic [AN_COUNT-1:0]  AIN_WR_DATA,
    output var  logic [AN_COUNT-1:0]  AIN_ENABLE,
    output var  logic [AN_COUNT-1:0]  ANALOG_CONNECT,
    output var  logic [PIN_COUNT-1:0] DIG_IN
);

    // ***************************************
    // State
    // ***************************************
    logic [AN_COUNT-1:0]  analog_input_enable_reg;
    logic [PIN_COUNT-1:0] pin_meta;
    logic [PIN_COUNT-1:0] pin_sync;
    logic [PIN_COUNT-1:0] dedicated;
    logic [PIN_COUNT-1:0] analog;
    logic [PIN_COUNT-1:0] res_sel;
    logic [PIN_COUNT-1:0] drive_val;
    logic [PIN_COUNT-1:0] drive_en;
    logic [PIN_COUNT-1:0] bus_low;
    logic [PIN_COUNT-1:0] next_out;
    logic [PIN_COUNT-1:0] next_oe_b;
    logic [PIN_COUNT-1:0] next_dig_in;

    // ***************************************
    // Per pin selection
    // ***************************************
    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i++) begin : g_pin
            if (i == IDX_UART0_RX) begin : g_rx0
                assign dedicated[i] = RX_ACTIVE_UART0;
            end else if (i == IDX_UART1_RX) begin : g_rx1
                assign dedicated[i] = RX_ACTIVE_UART1;
            end else if (i == IDX_SIO2_IN) begin : g_rx2
                assign dedicated[i] = RX_ACTIVE_SIO2;
            end else begin : g_norx
                assign dedicated[i] = 1'b0;
            end
            if (i >= AN_BASE && i < AN_BASE + AN_COUNT) begin : g_an
                assign analog[i] = analog_input_enable_reg[i-AN_BASE];
            end else begin : g_dig
                assign analog[i] = 1'b0;
            end
            assign res_sel[i]   = RES_OE[i] & ~dedicated[i];
            assign drive_val[i] = res_sel[i] ? RES_OUT[i] : PORT_DATA[i];
            assign drive_en[i]  = ~dedicated[i] & ~analog[i]
                                & (res_sel[i] | PORT_DIR[i]);
            if (i == IDX_SDA || i == IDX_SCL) begin : g_od
                // Bus pull requests only count while the interface runs
                assign bus_low[i]   = BUS_ACTIVE
                                    & (i == IDX_SDA ? BUS_SDA_LOW
                                                    : BUS_SCL_LOW);
                assign next_out[i]  = 1'b0;
                assign next_oe_b[i] = ~((drive_en[i] & ~drive_val[i])
                                      | bus_low[i]);
            end else begin : g_cmos
                assign bus_low[i]   = 1'b0;
                assign next_out[i]  = drive_val[i];
                assign next_oe_b[i] = ~drive_en[i];
            end
            assign next_dig_in[i] = pin_sync[i] & ~STANDBY & ~analog[i];
        end
    endgenerate

    // ***************************************
    // Registers
    // ***************************************
    // analog enable reset
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            analog_input_enable_reg <= AIN_RESET;
        end else if (AIN_WR) begin
            analog_input_enable_reg <= AIN_WR_DATA;
        end
    end

    // Pad levels are asynchronous to the system clock
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            pin_meta <= PIN_ZERO;
            pin_sync <= PIN_ZERO;
        end else begin
            pin_meta <= PIN_IN;
            pin_sync <= pin_meta;
        end
    end

    // Pins released at reset so nothing fights the board
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            PIN_OUT        <= PIN_ZERO;
            PIN_OE_B       <= PIN_ONES;
            DIG_IN         <= PIN_ZERO;
            AIN_ENABLE     <= AIN_RESET;
            ANALOG_CONNECT <= AIN_ZERO;
        end else begin
            PIN_OUT        <= next_out;
            PIN_OE_B       <= next_oe_b;
            DIG_IN         <= next_dig_in;
            AIN_ENABLE     <= analog_input_enable_reg;
            ANALOG_CONNECT <= analog_input_enable_reg;
        end
    end

    // ***************************************
    // Checks
    // ***************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    a_analog_no_drive: assert property (
        RST_B && analog_input_enable_reg[0]
        |=> PIN_OE_B[AN_BASE] && ANALOG_CONNECT[0])
        else $error("analog pin driven or not connected");

    a_standby_blocks_in: assert property (
        STANDBY |=> DIG_IN == PIN_ZERO)
        else $error("input seen during standby");

    a_uart_clk_gate: assert property (
        !RES_OE[IDX_UART0_CLOCK] && !PORT_DIR[IDX_UART0_CLOCK]
        |=> PIN_OE_B[IDX_UART0_CLOCK])
        else $error("uart clock pin driven without permission");

    a_rx_pin_dedicated: assert property (
        RX_ACTIVE_UART0 |=> PIN_OE_B[IDX_UART0_RX])
        else $error("receive pin driven in receive mode");

    a_shared_out_path: assert property (
        RES_OE[IDX_PULSE_GEN0] |=> !PIN_OE_B[IDX_PULSE_GEN0]
        && PIN_OUT[IDX_PULSE_GEN0] == $past(RES_OUT[IDX_PULSE_GEN0]))
        else $error("resource output not on pin");

    a_od_never_high: assert property (
        !PIN_OE_B[IDX_SDA] |-> !PIN_OUT[IDX_SDA] && !PIN_OUT[IDX_SCL])
        else $error("open drain pin driven high");

    a_sio_out_gate: assert property (
        RES_OE[IDX_SIO1_OUT] && !analog[IDX_SIO1_OUT]
        |=> PIN_OUT[IDX_SIO1_OUT] == $past(RES_OUT[IDX_SIO1_OUT])
        && !PIN_OE_B[IDX_SIO1_OUT])
        else $error("serial out pin not carrying channel");

    a_ain_reset_ones: assert property (
        disable iff (1'b0) !RST_B ##1 RST_B |=> AIN_ENABLE == AIN_RESET)
        else $error("analog enable not all ones after reset");

    a_port_fallback: assert property (
        !RES_OE[IDX_PULSE_GEN1] && PORT_DIR[IDX_PULSE_GEN1]
        |=> PIN_OUT[IDX_PULSE_GEN1] == $past(PORT_DATA[IDX_PULSE_GEN1]))
        else $error("port data not on pin");

    a_analog_in_low: assert property (
        $past(analog_input_enable_reg[0]) |-> !DIG_IN[AN_BASE])
        else $error("analog pin digital input not held low");

    a_bus_pulls_low: assert property (
        BUS_ACTIVE && BUS_SDA_LOW |=> !PIN_OE_B[IDX_SDA] && !PIN_OUT[IDX_SDA])
        else $error("bus low request not on data pin");

    a_od_released_high: assert property (
        !BUS_ACTIVE && !RES_OE[IDX_SCL] && !PORT_DIR[IDX_SCL]
        |=> PIN_OE_B[IDX_SCL])
        else $error("open drain clock pin not released");

    a_sio2_in_dedicated: assert property (
        RX_ACTIVE_SIO2 |=> PIN_OE_B[IDX_SIO2_IN])
        else $error("serial input pin driven in input mode");

    a_uart1_rx_dedicated: assert property (
        RX_ACTIVE_UART1 |=> PIN_OE_B[IDX_UART1_RX])
        else $error("uart1 receive pin driven in receive mode");

    c_pulse_gen_out: cover property (RES_OE[IDX_PULSE_GEN0] ##1 1'b1);
    c_bus_pull_low:  cover property (BUS_ACTIVE && BUS_SDA_LOW);
    c_ain_write:     cover property (AIN_WR && AIN_WR_DATA == AIN_ZERO);
    c_standby:       cover property (STANDBY ##1 !STANDBY);
    c_rx_dedicated:  cover property (RX_ACTIVE_UART1 && RES_OE[IDX_UART1_RX]);

endmodule : spfs_pin_mux

`default_nettype wire

/* File: verif/spfs_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spfs_board_model
    import spfs_pkg::*;
(
    input  wire logic [PIN_COUNT-1:0] PIN_OUT,
    input  wire logic [PIN_COUNT-1:0] PIN_OE_B,
    input  wire logic [PIN_COUNT-1:0] EXT,
    output var  logic [PIN_COUNT-1:0] PAD
);
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (PIN_OE_B[i] == 1'b0)
                PAD[i] = PIN_OUT[i];
            else if (i == IDX_SDA || i == IDX_SCL)
                PAD[i] = 1'b1;
            else
                PAD[i] = EXT[i];
        end
    end
endmodule : spfs_board_model
`default_nettype wire

/* File: verif/shared_pin_function_select_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module shared_pin_function_select_tb;
    import spfs_pkg::*;
    logic clk = 0, rst_b = 0, wr = 0, stby = 0, bus = 0, sda = 0, scl = 0;
    logic rx0 = 0, rx1 = 0, rx2 = 0;
    logic [PIN_COUNT-1:0] pdat = '0, pdir = '0, rout = '0, roe = '0, ext = '0;
    logic [PIN_COUNT-1:0] pad, pout, poe_b, dig, e_oe, e_out, e_dig;
    logic [AN_COUNT-1:0]  wdat = '0, ain = AIN_RESET, aen, acon;
    logic [PIN_COUNT-1:0] t_dir;
    logic [AN_COUNT-1:0]  t_wdat;
    logic                 t_stby, t_bus;
    int failures = 0, checked = 0, cycles = 0;
    // Slow clock keeps sync flops simple
    always #20 clk = ~clk;
    spfs_pin_mux DUT (.SYS_CLK(clk), .RST_B(rst_b), .PIN_IN(pad),
        .PIN_OUT(pout), .PIN_OE_B(poe_b), .PORT_DATA(pdat), .PORT_DIR(pdir),
        .RES_OUT(rout), .RES_OE(roe), .RX_ACTIVE_UART0(rx0),
        .RX_ACTIVE_UART1(rx1), .RX_ACTIVE_SIO2(rx2), .BUS_ACTIVE(bus),
        .BUS_SDA_LOW(sda), .BUS_SCL_LOW(scl), .STANDBY(stby), .AIN_WR(wr),
        .AIN_WR_DATA(wdat), .AIN_ENABLE(aen), .ANALOG_CONNECT(acon),
        .DIG_IN(dig));
    spfs_board_model board (.PIN_OUT(pout), .PIN_OE_B(poe_b), .EXT(ext),
        .PAD(pad));
    task automatic conclude;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Pad value is worked out here, not read back from the model
    function automatic void predict();
        for (int i = 0; i < PIN_COUNT; i++) begin
            logic an, d, v, od;
            an = (i >= AN_BASE && i < AN_BASE + AN_COUNT) && ain[i-AN_BASE];
            od = (i == IDX_SDA || i == IDX_SCL);
            d = roe[i] | pdir[i];
            v = roe[i] ? rout[i] : pdat[i];
            if (an || (i == IDX_UART0_RX && rx0) || (i == IDX_UART1_RX && rx1)
                || (i == IDX_SIO2_IN && rx2))
                d = 1'b0;
            if (od) begin
                d = (d && !v) || (bus && (i == IDX_SDA ? sda : scl));
                v = 1'b0;
            end
            e_oe[i] = !d;
            e_out[i] = v;
            e_dig[i] = (stby || an) ? 1'b0 : (d ? v : (od ? 1'b1 : ext[i]));
        end
    endfunction : predict
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'h25d9));
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(negedge clk);
        check(aen, AIN_RESET);
        check(acon, AIN_RESET);
        check(poe_b, PIN_ONES);
        $display("reset test done");
        for (int n = 0; n < 200; n++) begin
            @(posedge clk);
            t_wdat = AN_COUNT'($urandom);
            t_dir  = PIN_COUNT'($urandom);
            t_stby = ($urandom % 8) == 0;
            t_bus  = 1'($urandom);
            if (n == 0) begin
                t_wdat = AIN_ZERO;
                t_dir  = PIN_ONES;
            end
            if (n == 1)
                t_stby = 1'b1;
            // port stays input while bus runs
            if (t_bus)
                t_dir[IDX_SCL:IDX_SDA] = 2'b00;
            pdat <= PIN_COUNT'($urandom);
            rout <= PIN_COUNT'($urandom);
            roe <= PIN_COUNT'($urandom);
            ext <= PIN_COUNT'($urandom);
            {rx0, rx1, rx2} <= 3'($urandom);
            {sda, scl} <= 2'($urandom);
            pdir <= t_dir;
            stby <= t_stby;
            bus <= t_bus;
            wr <= 1'b1;
            wdat <= t_wdat;
            @(posedge clk);
            wr <= 1'b0;
            ain = t_wdat;
            repeat (6) @(negedge clk);
            predict();
            check(poe_b, e_oe);
            check(pout & ~e_oe, e_out & ~e_oe);
            check(dig, e_dig);
            check(acon, ain);
            check(aen, ain);
        end
        $display("stimulus test done");
        conclude();
    end
endmodule : shared_pin_function_select_tb
`default_nettype wire
